//--- include/phpm_pkg.sv
// Behaviour
// - The strap level at reset picks the mode of both parallel and host pin muxes.
// - Strap low: memory interface off; A[17:2] carry host address, D[15:0] host data.
// - Strap low: A[21:18], D[31:16], C0..C15 become general-purpose bits 3..0, 19..4, 20..35.
// - Non-multiplexed host mode routes 16 address, 16 data and 9 control signals.
// - Mode bit reads 0 for non-multiplexed host plus GPIO, 1 for full memory interface.
// - Strap high: memory interface on, A[21:2] and D[31:0] carry its address and data.
// - Strap high: C0..C15 carry the memory interface control functions in fixed order.
// - Strap high: host port runs multiplexed, address and data over eight data pins.
// - Strap low: host data pins become bits 43..36, control pins bits 44 and 45.
// - Strap high: host data pins carry host data 7..0, HC0 strobe, HC1 byte id.
// - After reset the bus selection value reports the strap-chosen configuration.
// - Mode bit is bit 0 of the 16-bit bus selection register at 0x6C00.
// - Memory interface clock gated off when unselected; accesses then may raise bus error.
package phpm_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;
	localparam int CTRL_W = 16;
	localparam int HOST_PIN_W = 10;
	localparam int HOST_DATA_PIN_W = 8;
	localparam int HOST_ADDR_W = 16;
	localparam int HOST_DATA_W = 16;
	localparam int HOST_CTRL_W = 9;
	localparam int GPIO_W = 46;

	// General-purpose bit positions per pin group
	localparam int GPIO_ADDR_LO = 0;
	localparam int GPIO_ADDR_N = 4;
	localparam int GPIO_DATA_LO = 4;
	localparam int GPIO_DATA_N = 16;
	localparam int GPIO_CTRL_LO = 20;
	localparam int GPIO_HOST_LO = 36;

	// Control pin functions in memory interface mode
	localparam int CTRL_ASYNC_READ = 0;
	localparam int CTRL_ASYNC_OUT_EN = 1;
	localparam int CTRL_ASYNC_WRITE = 2;
	localparam int CTRL_ASYNC_READY = 3;
	localparam int CTRL_CHIP_SEL0 = 4;
	localparam int CTRL_BYTE_EN0 = 8;
	localparam int CTRL_SDRAM_CLK_EN = 12;
	localparam int CTRL_SYNC_OUT_EN3 = 13;
	localparam int CTRL_BUS_HOLD = 14;
	localparam int CTRL_BUS_GRANT_ACK = 15;
	localparam logic [15:0] CTRL_IN_MASK = (16'h0001 << CTRL_ASYNC_READY)
		| (16'h0001 << CTRL_BUS_HOLD);

	// Host control pin positions within the host pin group
	localparam int HOST_PIN_STROBE = 8;
	localparam int HOST_PIN_BYTE_ID = 9;

	// Bus selection register
	localparam logic [15:0] BSR_ADDR = 16'h6C00;
	localparam int BSR_W = 16;
	localparam int BSR_MODE_BIT = 0;
	localparam logic MODE_HOST_GPIO = 1'b0;
	localparam logic MODE_FULL_MEM = 1'b1;

	localparam int SYNC_W = 1 + HOST_CTRL_W + HOST_PIN_W + CTRL_W + DATA_W + ADDR_W;
	localparam logic [2:0] STRAP_SETTLE_CYC = 3'h4;

	typedef enum logic [2:0] {
		PHPM_ST_RESET = 3'b001,
		PHPM_ST_SETTLE = 3'b010,
		PHPM_ST_LOCKED = 3'b100
	} phpm_state_e;
endpackage

//--- hdl/phpm_sync3.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; a bit only changes once stages two and three agree
module phpm_sync3 #(
	parameter int W = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Per-bit agreement filters a single-cycle metastable resolution glitch
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_o <= '0;
		end else begin
			sync_o <= (s2_q & s3_q) | (sync_o & (s2_q | s3_q));
		end
	end
endmodule

//--- hdl/phpm_pad_sel.sv
`timescale 1ns/1ps
// Registered two-way pad selector: function a in mode 0, function b in mode 1
module phpm_pad_sel #(
	parameter int W = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic sel,
	input wire logic [W-1:0] a_o,
	input wire logic [W-1:0] a_oe,
	input wire logic [W-1:0] b_o,
	input wire logic [W-1:0] b_oe,
	output logic [W-1:0] pad_o,
	output logic [W-1:0] pad_oe
);
	// Pads stay undriven until the mode is locked, so no contention at power-up
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_o <= '0;
			pad_oe <= '0;
		end else if (!en) begin
			pad_o <= '0;
			pad_oe <= '0;
		end else if (sel) begin
			pad_o <= b_o;
			pad_oe <= b_oe;
		end else begin
			pad_o <= a_o;
			pad_oe <= a_oe;
		end
	end
endmodule

//--- hdl/phpm_pin_mux.sv
`timescale 1ns/1ps
module phpm_pin_mux (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic config_strap_pin,
	// Parallel pins A[21:2], D[31:0], C[15:0]
	input wire logic [19:0] pad_addr_i,
	output logic [19:0] pad_addr_o,
	output logic [19:0] pad_addr_oe,
	input wire logic [31:0] pad_data_i,
	output logic [31:0] pad_data_o,
	output logic [31:0] pad_data_oe,
	input wire logic [15:0] pad_ctrl_i,
	output logic [15:0] pad_ctrl_o,
	output logic [15:0] pad_ctrl_oe,
	// Host pins: data 7..0, host_ctrl_pin0, host_ctrl_pin1
	input wire logic [7:0] host_data_pins_i,
	output logic [7:0] host_data_pins_o,
	output logic [7:0] host_data_pins_oe,
	input wire logic host_ctrl_pin0_i,
	output logic host_ctrl_pin0_o,
	output logic host_ctrl_pin0_oe,
	input wire logic host_ctrl_pin1_i,
	output logic host_ctrl_pin1_o,
	output logic host_ctrl_pin1_oe,
	// Dedicated host control pins (select, direction, control lines)
	input wire logic [8:0] host_ctrl_lines_i,
	// External memory interface side
	input wire logic [19:0] ext_mem_addr_o,
	input wire logic [31:0] ext_mem_data_o,
	input wire logic ext_mem_data_oe,
	output logic [31:0] ext_mem_data_i,
	input wire logic [15:0] ext_mem_ctrl_o,
	input wire logic [15:0] ext_mem_ctrl_oe,
	output logic [15:0] ext_mem_ctrl_i,
	output logic ext_mem_clk_en,
	input wire logic ext_mem_req,
	input wire logic periph_timeout_en,
	output logic ext_mem_bus_err,
	// Host port interface side
	output logic host_port_en,
	output logic host_port_muxed,
	output logic [15:0] host_addr,
	output logic [15:0] host_port_data_i,
	input wire logic [15:0] host_port_data_o,
	input wire logic host_port_data_oe,
	output logic host_addr_strobe,
	output logic host_byte_id,
	output logic [8:0] host_port_ctrl,
	// Parallel general-purpose I/O
	input wire logic [45:0] parallel_gpio_o,
	input wire logic [45:0] parallel_gpio_oe,
	output logic [45:0] parallel_gpio_i,
	// Mux status
	output logic mux_locked,
	output logic [15:0] bus_select_reg
);
	phpm_pkg::phpm_state_e state_q;
	logic [2:0] settle_q;
	logic mode_q;
	logic locked;
	logic mode_mem;
	logic mode_host;
	logic [phpm_pkg::SYNC_W-1:0] sync_in;
	logic [phpm_pkg::SYNC_W-1:0] sync_out;
	logic [19:0] s_addr;
	logic [31:0] s_data;
	logic [15:0] s_ctrl;
	logic [9:0] s_host;
	logic [8:0] s_hctl;
	logic s_strap;
	logic [9:0] host_pad_o;
	logic [9:0] host_pad_oe;
	logic [19:0] addr_a_o;
	logic [19:0] addr_a_oe;
	logic [31:0] data_a_o;
	logic [31:0] data_a_oe;
	logic [9:0] host_b_o;
	logic [9:0] host_b_oe;

	assign sync_in = {config_strap_pin, host_ctrl_lines_i, host_ctrl_pin1_i, host_ctrl_pin0_i,
		host_data_pins_i, pad_ctrl_i, pad_data_i, pad_addr_i};

	phpm_sync3 #(
		.W(phpm_pkg::SYNC_W)
	) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_i(sync_in),
		.sync_o(sync_out)
	);

	assign {s_strap, s_hctl, s_host, s_ctrl, s_data, s_addr} = sync_out;

	// Strap capture: wait for the synchroniser to fill, then freeze the mode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= phpm_pkg::PHPM_ST_RESET;
			settle_q <= '0;
		end else begin
			case (state_q)
				phpm_pkg::PHPM_ST_RESET: begin
					state_q <= phpm_pkg::PHPM_ST_SETTLE;
					settle_q <= '0;
				end
				phpm_pkg::PHPM_ST_SETTLE: begin
					settle_q <= settle_q + 3'h1;
					if (settle_q == phpm_pkg::STRAP_SETTLE_CYC) begin
						state_q <= phpm_pkg::PHPM_ST_LOCKED;
					end
				end
				phpm_pkg::PHPM_ST_LOCKED: begin
					state_q <= phpm_pkg::PHPM_ST_LOCKED;
				end
				default: begin
					state_q <= phpm_pkg::PHPM_ST_RESET;
				end
			endcase
		end
	end

	// No write path exists, so the mode cannot be changed by software after reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= phpm_pkg::MODE_HOST_GPIO;
		end else if (state_q == phpm_pkg::PHPM_ST_SETTLE
			&& settle_q == phpm_pkg::STRAP_SETTLE_CYC) begin
			mode_q <= s_strap;
		end
	end

	assign locked = (state_q == phpm_pkg::PHPM_ST_LOCKED);
	assign mode_mem = locked && (mode_q == phpm_pkg::MODE_FULL_MEM);
	assign mode_host = locked && (mode_q == phpm_pkg::MODE_HOST_GPIO);
	assign mux_locked = locked;

	always_comb begin
		bus_select_reg = '0;
		bus_select_reg[phpm_pkg::BSR_MODE_BIT] = locked & mode_q;
	end

	// Memory interface clock gating and bus error on access while unselected
	assign ext_mem_clk_en = mode_mem;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_mem_bus_err <= 1'b0;
		end else begin
			ext_mem_bus_err <= ext_mem_req && !mode_mem && periph_timeout_en;
		end
	end

	// Mode 0 drive sets: host address is an input, upper address bits are GPIO
	always_comb begin
		addr_a_o = '0;
		addr_a_oe = '0;
		addr_a_o[phpm_pkg::HOST_ADDR_W +: phpm_pkg::GPIO_ADDR_N] =
			parallel_gpio_o[phpm_pkg::GPIO_ADDR_LO +: phpm_pkg::GPIO_ADDR_N];
		addr_a_oe[phpm_pkg::HOST_ADDR_W +: phpm_pkg::GPIO_ADDR_N] =
			parallel_gpio_oe[phpm_pkg::GPIO_ADDR_LO +: phpm_pkg::GPIO_ADDR_N];
	end

	assign data_a_o = {parallel_gpio_o[phpm_pkg::GPIO_DATA_LO +: phpm_pkg::GPIO_DATA_N],
		host_port_data_o};
	assign data_a_oe = {parallel_gpio_oe[phpm_pkg::GPIO_DATA_LO +: phpm_pkg::GPIO_DATA_N],
		{phpm_pkg::HOST_DATA_W{host_port_data_oe}}};

	// Mode 1 host pins: HC0/HC1 are host inputs, data pins carry the low byte
	assign host_b_o = {2'h0, host_port_data_o[phpm_pkg::HOST_DATA_PIN_W-1:0]};
	assign host_b_oe = {2'h0, {phpm_pkg::HOST_DATA_PIN_W{host_port_data_oe}}};

	phpm_pad_sel #(
		.W(phpm_pkg::ADDR_W)
	) u_addr (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.en(locked),
		.sel(mode_q),
		.a_o(addr_a_o),
		.a_oe(addr_a_oe),
		.b_o(ext_mem_addr_o),
		.b_oe({phpm_pkg::ADDR_W{1'b1}}),
		.pad_o(pad_addr_o),
		.pad_oe(pad_addr_oe)
	);

	phpm_pad_sel #(
		.W(phpm_pkg::DATA_W)
	) u_data (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.en(locked),
		.sel(mode_q),
		.a_o(data_a_o),
		.a_oe(data_a_oe),
		.b_o(ext_mem_data_o),
		.b_oe({phpm_pkg::DATA_W{ext_mem_data_oe}}),
		.pad_o(pad_data_o),
		.pad_oe(pad_data_oe)
	);

	phpm_pad_sel #(
		.W(phpm_pkg::CTRL_W)
	) u_ctrl (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.en(locked),
		.sel(mode_q),
		.a_o(parallel_gpio_o[phpm_pkg::GPIO_CTRL_LO +: phpm_pkg::CTRL_W]),
		.a_oe(parallel_gpio_oe[phpm_pkg::GPIO_CTRL_LO +: phpm_pkg::CTRL_W]),
		.b_o(ext_mem_ctrl_o),
		.b_oe(ext_mem_ctrl_oe & ~phpm_pkg::CTRL_IN_MASK),
		.pad_o(pad_ctrl_o),
		.pad_oe(pad_ctrl_oe)
	);

	phpm_pad_sel #(
		.W(phpm_pkg::HOST_PIN_W)
	) u_host (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.en(locked),
		.sel(mode_q),
		.a_o(parallel_gpio_o[phpm_pkg::GPIO_HOST_LO +: phpm_pkg::HOST_PIN_W]),
		.a_oe(parallel_gpio_oe[phpm_pkg::GPIO_HOST_LO +: phpm_pkg::HOST_PIN_W]),
		.b_o(host_b_o),
		.b_oe(host_b_oe),
		.pad_o(host_pad_o),
		.pad_oe(host_pad_oe)
	);

	assign host_data_pins_o = host_pad_o[phpm_pkg::HOST_DATA_PIN_W-1:0];
	assign host_data_pins_oe = host_pad_oe[phpm_pkg::HOST_DATA_PIN_W-1:0];
	assign host_ctrl_pin0_o = host_pad_o[phpm_pkg::HOST_PIN_STROBE];
	assign host_ctrl_pin0_oe = host_pad_oe[phpm_pkg::HOST_PIN_STROBE];
	assign host_ctrl_pin1_o = host_pad_o[phpm_pkg::HOST_PIN_BYTE_ID];
	assign host_ctrl_pin1_oe = host_pad_oe[phpm_pkg::HOST_PIN_BYTE_ID];

	// Inbound routing; consumers of the unselected function see zero
	assign parallel_gpio_i = mode_host ? {s_host, s_ctrl,
		s_data[phpm_pkg::HOST_DATA_W +: phpm_pkg::GPIO_DATA_N],
		s_addr[phpm_pkg::HOST_ADDR_W +: phpm_pkg::GPIO_ADDR_N]} : '0;
	assign ext_mem_data_i = mode_mem ? s_data : '0;
	assign ext_mem_ctrl_i = mode_mem ? (s_ctrl & phpm_pkg::CTRL_IN_MASK) : '0;

	assign host_port_en = locked;
	assign host_port_muxed = mode_mem;
	assign host_addr = mode_host ? s_addr[phpm_pkg::HOST_ADDR_W-1:0] : '0;
	assign host_port_data_i = mode_host ? s_data[phpm_pkg::HOST_DATA_W-1:0]
		: (mode_mem ? {8'h00, s_host[phpm_pkg::HOST_DATA_PIN_W-1:0]} : '0);
	assign host_addr_strobe = mode_mem & s_host[phpm_pkg::HOST_PIN_STROBE];
	assign host_byte_id = mode_mem & s_host[phpm_pkg::HOST_PIN_BYTE_ID];
	// Dedicated control lines serve both host modes; 9 signals in non-multiplexed use
	assign host_port_ctrl = locked ? s_hctl : '0;

	a_mode_held: assert property (@(posedge core_clk) disable iff (!rst_n)
		locked && $past(locked) |-> $stable(mode_q))
		else $error("mux mode changed after lock");
	a_mode_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(locked) |-> mode_q == $past(s_strap))
		else $error("mode does not match synchronised strap");
	a_bsr_report: assert property (@(posedge core_clk) disable iff (!rst_n)
		locked |-> bus_select_reg == {15'h0000, mode_q})
		else $error("bus select value wrong");
	a_bsr_polarity: assert property (@(posedge core_clk) disable iff (!rst_n)
		locked |-> bus_select_reg[0] == ext_mem_clk_en)
		else $error("mode bit and memory clock disagree");
	a_err_raise: assert property (@(posedge core_clk) disable iff (!rst_n)
		ext_mem_req && !ext_mem_clk_en && periph_timeout_en |=> ext_mem_bus_err)
		else $error("bus error missing");
	a_err_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
		ext_mem_clk_en || !periph_timeout_en |=> !ext_mem_bus_err)
		else $error("spurious bus error");
	a_unlocked_float: assert property (@(posedge core_clk) disable iff (!rst_n)
		!locked |=> pad_addr_oe == '0 && pad_data_oe == '0 && pad_ctrl_oe == '0)
		else $error("pads driven before lock");
	a_mem_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_mem |=> pad_addr_o == $past(ext_mem_addr_o) && pad_addr_oe == '1)
		else $error("memory address not routed");
	a_host_addr_in: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_host |=> pad_addr_oe[15:0] == 16'h0000)
		else $error("host address pins driven");
	a_gpio_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_host |=> pad_data_o[31:16] == $past(parallel_gpio_o[19:4]))
		else $error("upper data not general purpose");
	a_ctrl_inputs: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_mem |=> !pad_ctrl_oe[3] && !pad_ctrl_oe[14])
		else $error("ready or hold pin driven");
	a_host_gpio: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_host |=> host_data_pins_o == $past(parallel_gpio_o[43:36]))
		else $error("host data pins not general purpose");
	a_host_muxed: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_mem |=> host_data_pins_o == $past(host_port_data_o[7:0]) && !host_ctrl_pin0_oe)
		else $error("multiplexed host routing wrong");
	a_host_strobe_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_host |-> !host_addr_strobe && !host_byte_id)
		else $error("host strobe active in general-purpose mode");
	a_mem_in_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_host |-> ext_mem_data_i == '0 && ext_mem_ctrl_i == '0)
		else $error("memory inputs active while interface off");
	a_gpio_in_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_mem |-> parallel_gpio_i == '0)
		else $error("general-purpose inputs active in memory mode");
	a_host_data_out: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_host |=> pad_data_o[15:0] == $past(host_port_data_o))
		else $error("host data not routed to lower data pins");
endmodule

//--- testbench/phpm_far_pins.sv
`timescale 1ns/1ps
// Far side of a pin group: memory devices or an external host
module phpm_far_pins #(
	parameter int W = 8
) (
	input wire logic [W-1:0] pad_o,
	input wire logic [W-1:0] pad_oe,
	input wire logic [W-1:0] far_val,
	output logic [W-1:0] pad_i
);
	// The far party drives only bits the block has released, so a wrong enable shows up
	assign pad_i = (pad_o & pad_oe) | (far_val & ~pad_oe);
endmodule

//--- testbench/test_phpm_pin_mux.sv
`timescale 1ns/1ps
module test_phpm_pin_mux;
	logic core_clk = 0;
	logic rst_n = 0;
	logic strap = 0;
	logic [19:0] a_o, a_oe, a_i, a_far = 0, m_addr = 0;
	logic [31:0] d_o, d_oe, d_i, d_far = 0, m_data = 0, m_data_in;
	logic [15:0] c_o, c_oe, c_i, c_far = 0, m_ctrl = 0, m_ctrl_oe = 0, m_ctrl_in;
	logic [9:0] h_o, h_oe, h_i, h_far = 0;
	logic [8:0] hc_lines = 0, host_ctrl;
	logic m_data_oe = 0, m_req = 0, to_en = 0, clk_en, bus_err;
	logic hp_en, hp_muxed, strobe, byte_id, locked;
	logic [15:0] haddr, hdata_in, hdata_out = 0, bsr;
	logic hdata_oe = 0;
	logic [45:0] g_o = 0, g_oe = 0, g_i;
	int bad_count = 0;
	int n_checks = 0;

	always #2.5 core_clk = ~core_clk;

	phpm_far_pins #(.W(20)) far_a (.pad_o(a_o), .pad_oe(a_oe), .far_val(a_far), .pad_i(a_i));
	phpm_far_pins #(.W(32)) far_d (.pad_o(d_o), .pad_oe(d_oe), .far_val(d_far), .pad_i(d_i));
	phpm_far_pins #(.W(16)) far_c (.pad_o(c_o), .pad_oe(c_oe), .far_val(c_far), .pad_i(c_i));
	phpm_far_pins #(.W(10)) far_h (.pad_o(h_o), .pad_oe(h_oe), .far_val(h_far), .pad_i(h_i));

	phpm_pin_mux dut (
		.core_clk(core_clk), .rst_n(rst_n), .config_strap_pin(strap),
		.pad_addr_i(a_i), .pad_addr_o(a_o), .pad_addr_oe(a_oe),
		.pad_data_i(d_i), .pad_data_o(d_o), .pad_data_oe(d_oe),
		.pad_ctrl_i(c_i), .pad_ctrl_o(c_o), .pad_ctrl_oe(c_oe),
		.host_data_pins_i(h_i[7:0]), .host_data_pins_o(h_o[7:0]),
		.host_data_pins_oe(h_oe[7:0]),
		.host_ctrl_pin0_i(h_i[8]), .host_ctrl_pin0_o(h_o[8]), .host_ctrl_pin0_oe(h_oe[8]),
		.host_ctrl_pin1_i(h_i[9]), .host_ctrl_pin1_o(h_o[9]), .host_ctrl_pin1_oe(h_oe[9]),
		.host_ctrl_lines_i(hc_lines),
		.ext_mem_addr_o(m_addr), .ext_mem_data_o(m_data), .ext_mem_data_oe(m_data_oe),
		.ext_mem_data_i(m_data_in), .ext_mem_ctrl_o(m_ctrl), .ext_mem_ctrl_oe(m_ctrl_oe),
		.ext_mem_ctrl_i(m_ctrl_in), .ext_mem_clk_en(clk_en), .ext_mem_req(m_req),
		.periph_timeout_en(to_en), .ext_mem_bus_err(bus_err),
		.host_port_en(hp_en), .host_port_muxed(hp_muxed), .host_addr(haddr),
		.host_port_data_i(hdata_in), .host_port_data_o(hdata_out),
		.host_port_data_oe(hdata_oe), .host_addr_strobe(strobe), .host_byte_id(byte_id),
		.host_port_ctrl(host_ctrl),
		.parallel_gpio_o(g_o), .parallel_gpio_oe(g_oe), .parallel_gpio_i(g_i),
		.mux_locked(locked), .bus_select_reg(bsr)
	);

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic reset_to(input logic mode);
		@(posedge core_clk);
		rst_n <= 1'b0;
		strap <= mode;
		wait_clk(10);
		rst_n <= 1'b1;
		// Lock lands on the sixth edge after release; spare edges absorb sync latency
		wait_clk(10);
		#1;
	endtask

	// One request pulse, error expected on the following cycle only
	task automatic err_probe(input logic en, input logic exp);
		@(posedge core_clk);
		to_en <= en;
		m_req <= 1'b1;
		@(posedge core_clk);
		m_req <= 1'b0;
		#1;
		chk(bus_err, exp);
		@(posedge core_clk);
		#1;
		chk(bus_err, 1'b0);
	endtask

	task automatic t_full_mem;
		reset_to(1'b1);
		chk(locked, 1'b1);
		chk(bsr, 16'h0001);
		chk(clk_en, 1'b1);
		chk(hp_muxed, 1'b1);
		@(posedge core_clk);
		strap <= 1'b0;
		m_addr <= 20'hA5A5A;
		m_data <= 32'hDEADBEEF;
		m_data_oe <= 1'b1;
		m_ctrl <= 16'h5A5A;
		m_ctrl_oe <= 16'hFFFF;
		c_far <= 16'hFFFF;
		h_far <= 10'h3A5;
		wait_clk(6);
		#1;
		chk(bsr, 16'h0001);
		chk(a_o, 20'hA5A5A);
		chk(a_oe, 20'hFFFFF);
		chk(d_o, 32'hDEADBEEF);
		chk(c_oe, 16'hBFF7);
		chk(c_o & 16'hBFF7, 16'h1A52);
		chk(m_ctrl_in, 16'h4008);
		chk(hdata_in, 16'h00A5);
		chk(strobe, 1'b1);
		chk(byte_id, 1'b1);
		chk(g_i, 46'h0);
		@(posedge core_clk);
		hdata_out <= 16'h003C;
		hdata_oe <= 1'b1;
		m_data_oe <= 1'b0;
		d_far <= 32'h13579BDF;
		wait_clk(6);
		#1;
		chk(h_o[7:0], 8'h3C);
		chk(h_oe[7:0], 8'hFF);
		chk(m_data_in, 32'h13579BDF);
		err_probe(1'b1, 1'b0);
		@(posedge core_clk);
		hdata_oe <= 1'b0;
		m_ctrl_oe <= 16'h0000;
	endtask

	task automatic t_host_gpio;
		reset_to(1'b0);
		chk(locked, 1'b1);
		chk(bsr, 16'h0000);
		chk(clk_en, 1'b0);
		chk(hp_en, 1'b1);
		chk(hp_muxed, 1'b0);
		@(posedge core_clk);
		a_far <= 20'h91234;
		d_far <= 32'hC3C35AA5;
		c_far <= 16'h6E17;
		h_far <= 10'h296;
		hc_lines <= 9'h1A5;
		wait_clk(6);
		#1;
		chk(haddr, 16'h1234);
		chk(hdata_in, 16'h5AA5);
		chk(host_ctrl, 9'h1A5);
		chk(g_i, {10'h296, 16'h6E17, 16'hC3C3, 4'h9});
		chk(m_data_in, 32'h0);
		chk(strobe, 1'b0);
		@(posedge core_clk);
		g_o <= {10'h2A9, 16'hCDEF, 16'h0123, 4'h5};
		g_oe <= {46{1'b1}};
		hdata_out <= 16'hBEEF;
		hdata_oe <= 1'b1;
		wait_clk(3);
		#1;
		chk(a_o[19:16], 4'h5);
		chk(a_oe, 20'hF0000);
		chk(d_o, 32'h0123BEEF);
		chk(d_oe, 32'hFFFFFFFF);
		chk(c_o, 16'hCDEF);
		chk(h_o, 10'h2A9);
		chk(h_oe, 10'h3FF);
		err_probe(1'b1, 1'b1);
		err_probe(1'b0, 1'b0);
	endtask

	task automatic wrap_up;
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Both scenarios need well under a few hundred cycles
	initial begin
		wait_clk(4000);
		bad_count++;
		wrap_up();
	end

	initial begin
		t_full_mem();
		t_host_gpio();
		wrap_up();
	end
endmodule
